// ---- rtl/rsfu_pkg.sv ----
/*
 * Shared constants and types for the raw serial frame unit.
 * Assumes a 10 MHz system clock and byte-wide serial interfaces outside.
 */
`default_nettype none
package rsfu_pkg;
    localparam int unsigned FRAME_MAX_BYTES = 256;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned DELAY_STEP_MS   = 10;
    localparam int unsigned DELAY_MAX_MS    = 99_990;
    localparam int unsigned STEP_CYCLES     = CLK_HZ / 1000 * DELAY_STEP_MS;
    localparam int unsigned DELAY_STEPS_MAX = DELAY_MAX_MS / DELAY_STEP_MS;
    localparam logic [7:0]  CODE_CR         = 8'h0d;
    localparam logic [7:0]  CODE_LF         = 8'h0a;
    localparam logic [8:0]  LEN_ZERO        = 9'h000;

    typedef enum logic [1:0] {
        RSFU_END_NONE = 2'b00,
        RSFU_END_BYTE = 2'b01,
        RSFU_END_CRLF = 2'b10
    } rsfu_end_mode_t;

    typedef struct packed {
        logic           lead_en;
        logic [7:0]     leading_code;
        rsfu_end_mode_t end_mode;
        logic [7:0]     trailing_code;
        logic [13:0]    delay_steps;
    } rsfu_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rsfu_byte_t;
endpackage
`default_nettype wire

// ---- rtl/rsfu_delay.sv ----
/*
 * Send delay timer: counts whole 10 ms steps after a start pulse.
 * Assumes a start pulse from the same clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module rsfu_delay
    import rsfu_pkg::*;
#(
    parameter int unsigned STEP_CYC = STEP_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // Control
    input  wire logic        start_i,
    input  wire logic [13:0] steps_i,
    output logic             done_o
);
    initial begin
        if (STEP_CYC < 1 || STEP_CYC > 2**20) $error("rsfu_delay: bad STEP_CYC");
    end

    logic [19:0] tick_q;
    logic [13:0] steps_q;
    logic        run_q;
    wire         tick_end = (tick_q == 20'(STEP_CYC - 1));
    wire         last     = (steps_q == 14'h0000);

    // A zero-step delay ends in the cycle after the start pulse.
    assign done_o = run_q && last;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            run_q   <= 1'b0;
            tick_q  <= 20'h00000;
            steps_q <= 14'h0000;
        end else if (start_i) begin
            run_q   <= 1'b1;
            tick_q  <= 20'h00000;
            steps_q <= steps_i;
        end else if (run_q) begin
            if (last) begin
                run_q <= 1'b0;
            end else if (tick_end) begin
                tick_q  <= 20'h00000;
                steps_q <= steps_q - 14'h0001;
            end else begin
                tick_q <= tick_q + 20'h00001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/rsfu_top.sv ----
/*
 * Raw serial frame unit: frames memory payload for sending and strips
 * received frames down to their payload.
 * Assumes a serial transmitter with a byte valid/ready handshake and a receiver with byte valid only
 * on the line side and a memory sequencer on the internal side.
 */
// Functional notes
// (RL1) Frames never exceed 256 bytes including codes.
// (RL2) Optional leading byte, optional trailer byte or CRLF.
// (RL3) Payload limit is 256 minus code bytes.
// (RL4) Transmit only payload wrapped by configured codes.
// (RL5) Receive stores payload only, codes discarded.
// (RL6) First matching leading code starts the frame.
// (RL7) First matching trailing code ends the frame.
// (RL8) Payload byte equal to trailer ends frame early.
// (RL9) Send waits programmed 10 ms steps first.
// (RL10) No trailer: frame ends at payload limit.
// (RL11) Completion signalled only at trailer or limit.
`timescale 1ns/10ps
`default_nettype none
module rsfu_top
    import rsfu_pkg::*;
#(
    parameter int unsigned STEP_CYC = STEP_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // Configuration
    input  wire rsfu_cfg_t  cfg_i,
    // Send command and payload from memory
    input  wire logic       send_frame_cmd_alt_i,
    input  wire logic [8:0] send_len_i,
    output logic            pay_rd_o,
    input  wire rsfu_byte_t pay_rd_data_i,
    output logic            send_busy_o,
    output logic            send_done_o,
    // Line transmit
    output rsfu_byte_t      line_tx_o,
    input  wire logic       line_tx_ready_i,
    // Receive command, line receive and memory write
    input  wire logic       receive_frame_cmd_alt_i,
    input  wire rsfu_byte_t line_rx_i,
    output rsfu_byte_t      pay_wr_o,
    output logic            recv_done_o,
    output logic [8:0]      recv_len_o
);
    // The delay field is 14 bits wide, so the largest step count must fit in it.
    initial begin
        if (STEP_CYC < 1 || DELAY_STEPS_MAX >= 2**14) $error("rsfu_top: bad step settings");
    end

    // Payload capacity of the active format; shared by both directions.
    function automatic logic [8:0] pay_cap(input rsfu_cfg_t c);
        logic [1:0] codes;
        codes = {1'b0, c.lead_en};
        unique case (c.end_mode)
            RSFU_END_BYTE: codes = codes + 2'h1;
            RSFU_END_CRLF: codes = codes + 2'h2;
            default:       codes = codes + 2'h0;
        endcase
        pay_cap = 9'(FRAME_MAX_BYTES - 32'(codes)); // [RL1] [RL3]
    endfunction

    wire [8:0] cap = pay_cap(cfg_i);

    // Transmit side.
    typedef enum logic [2:0] {
        RSFU_TX_IDLE = 3'b000,
        RSFU_TX_WAIT = 3'b001,
        RSFU_TX_LEAD = 3'b010,
        RSFU_TX_DATA = 3'b011,
        RSFU_TX_END1 = 3'b100,
        RSFU_TX_END2 = 3'b101
    } rsfu_tx_st_t;

    rsfu_tx_st_t tx_st_q;
    logic [8:0]  tx_left_q;
    rsfu_byte_t  tx_q;
    logic        delay_done;

    rsfu_delay #(
        .STEP_CYC(STEP_CYC)
    ) u_delay (
        .clk_sys_i(clk_sys_i),
        .reset_i  (reset_i),
        .start_i  (send_frame_cmd_alt_i && tx_st_q == RSFU_TX_IDLE),
        .steps_i  (cfg_i.delay_steps),
        .done_o   (delay_done)
    );

    wire tx_free  = !tx_q.valid || line_tx_ready_i;
    wire has_tail = cfg_i.end_mode != RSFU_END_NONE;
    // A payload byte is fetched only when the output register can take it.
    assign pay_rd_o    = (tx_st_q == RSFU_TX_DATA) && tx_free && tx_left_q != LEN_ZERO;
    assign send_busy_o = tx_st_q != RSFU_TX_IDLE;
    assign line_tx_o   = tx_q;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tx_st_q     <= RSFU_TX_IDLE;
            tx_left_q   <= LEN_ZERO;
            tx_q        <= '0;
            send_done_o <= 1'b0;
        end else begin
            send_done_o <= 1'b0;
            if (tx_q.valid && line_tx_ready_i) tx_q.valid <= 1'b0;
            unique case (tx_st_q)
                RSFU_TX_IDLE: if (send_frame_cmd_alt_i) begin
                    tx_st_q   <= RSFU_TX_WAIT;
                    // Oversized requests are cut to the format's capacity.
                    tx_left_q <= (send_len_i > cap) ? cap : send_len_i; // [RL1] [RL3]
                end
                RSFU_TX_WAIT: if (delay_done) begin // [RL9]
                    tx_st_q <= cfg_i.lead_en ? RSFU_TX_LEAD : RSFU_TX_DATA;
                end
                RSFU_TX_LEAD: if (tx_free) begin
                    tx_q    <= '{valid: 1'b1, data: cfg_i.leading_code}; // [RL2] [RL4]
                    tx_st_q <= RSFU_TX_DATA;
                end
                RSFU_TX_DATA: if (tx_free) begin
                    if (tx_left_q == LEN_ZERO) begin
                        tx_st_q <= has_tail ? RSFU_TX_END1 : RSFU_TX_IDLE;
                        send_done_o <= !has_tail;
                    end else begin
                        // Memory answers the fetch combinationally.
                        tx_q      <= '{valid: 1'b1, data: pay_rd_data_i.data}; // [RL4]
                        tx_left_q <= tx_left_q - 9'h001;
                    end
                end
                RSFU_TX_END1: if (tx_free) begin
                    tx_q <= '{valid: 1'b1, data: (cfg_i.end_mode == RSFU_END_CRLF)
                                                 ? CODE_CR : cfg_i.trailing_code}; // [RL2]
                    tx_st_q     <= (cfg_i.end_mode == RSFU_END_CRLF) ? RSFU_TX_END2 : RSFU_TX_IDLE;
                    send_done_o <= cfg_i.end_mode != RSFU_END_CRLF;
                end
                RSFU_TX_END2: if (tx_free) begin
                    tx_q        <= '{valid: 1'b1, data: CODE_LF};
                    tx_st_q     <= RSFU_TX_IDLE;
                    send_done_o <= 1'b1;
                end
                default: tx_st_q <= RSFU_TX_IDLE;
            endcase
        end
    end

    // Receive side.
    typedef enum logic [1:0] {
        RSFU_RX_IDLE = 2'b00,
        RSFU_RX_HUNT = 2'b01,
        RSFU_RX_DATA = 2'b10,
        RSFU_RX_LF   = 2'b11
    } rsfu_rx_st_t;

    rsfu_rx_st_t rx_st_q;
    logic [8:0]  rx_cnt_q;
    wire         rx_v      = line_rx_i.valid;
    wire [7:0]   rx_b      = line_rx_i.data;
    wire         is_lead   = rx_v && rx_b == cfg_i.leading_code;
    wire         is_tail   = rx_v && cfg_i.end_mode == RSFU_END_BYTE
                             && rx_b == cfg_i.trailing_code;
    wire         is_cr     = rx_v && cfg_i.end_mode == RSFU_END_CRLF && rx_b == CODE_CR;
    wire         at_limit  = (rx_cnt_q + 9'h001) == cap;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rx_st_q     <= RSFU_RX_IDLE;
            rx_cnt_q    <= LEN_ZERO;
            pay_wr_o    <= '0;
            recv_done_o <= 1'b0;
            recv_len_o  <= LEN_ZERO;
        end else begin
            pay_wr_o.valid <= 1'b0;
            recv_done_o    <= 1'b0;
            unique case (rx_st_q)
                RSFU_RX_IDLE: if (receive_frame_cmd_alt_i) begin
                    rx_cnt_q <= LEN_ZERO;
                    rx_st_q  <= cfg_i.lead_en ? RSFU_RX_HUNT : RSFU_RX_DATA;
                end
                // Bytes before the first leading code are dropped; later
                // copies of that code are payload.
                RSFU_RX_HUNT: if (is_lead) rx_st_q <= RSFU_RX_DATA; // [RL5] [RL6]
                RSFU_RX_DATA: if (rx_v) begin
                    if (is_tail) begin // [RL7] [RL8]
                        rx_st_q     <= RSFU_RX_IDLE;
                        recv_done_o <= 1'b1; // [RL11]
                        recv_len_o  <= rx_cnt_q;
                    end else if (is_cr) begin
                        rx_st_q <= RSFU_RX_LF;
                    end else begin
                        pay_wr_o <= '{valid: 1'b1, data: rx_b}; // [RL5]
                        rx_cnt_q <= rx_cnt_q + 9'h001;
                        if (at_limit) begin // [RL10] [RL1]
                            rx_st_q     <= RSFU_RX_IDLE;
                            recv_done_o <= 1'b1; // [RL11]
                            recv_len_o  <= rx_cnt_q + 9'h001;
                        end
                    end
                end
                // A CR not followed by LF is stored as payload, but the byte after
                // it is lost: the memory port takes only one write per cycle.
                RSFU_RX_LF: if (rx_v) begin
                    if (rx_b == CODE_LF) begin
                        rx_st_q     <= RSFU_RX_IDLE;
                        recv_done_o <= 1'b1; // [RL11]
                        recv_len_o  <= rx_cnt_q;
                    end else begin
                        pay_wr_o <= '{valid: 1'b1, data: CODE_CR};
                        rx_cnt_q <= rx_cnt_q + 9'h001;
                        rx_st_q  <= at_limit ? RSFU_RX_IDLE : RSFU_RX_DATA;
                        recv_done_o <= at_limit;
                        recv_len_o  <= rx_cnt_q + 9'h001;
                    end
                end
            endcase
        end
    end

    // Checks.
    tx_len_cap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL3]
        tx_left_q <= cap) else $error("transmit count above payload capacity");
    rx_len_cap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL1]
        recv_done_o |-> recv_len_o <= cap) else $error("received length above capacity");
    tx_wait_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL9]
        (tx_st_q == RSFU_TX_WAIT && !delay_done) |=> !line_tx_o.valid || $past(line_tx_o.valid))
        else $error("byte sent during send delay");
    tx_lead_first_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL4]
        (tx_st_q == RSFU_TX_LEAD && tx_free) |=> line_tx_o.data == cfg_i.leading_code)
        else $error("leading code not sent first");
    tx_lf_after_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL2]
        (tx_st_q == RSFU_TX_END2 && tx_free) |=> line_tx_o.data == CODE_LF && send_done_o)
        else $error("line feed missing after carriage return");
    rx_tail_end_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL7]
        (rx_st_q == RSFU_RX_DATA && is_tail) |=> recv_done_o && !pay_wr_o.valid)
        else $error("trailing code stored or did not end frame");
    rx_hunt_drop_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL6]
        (rx_st_q == RSFU_RX_HUNT) |=> !pay_wr_o.valid) else $error("byte stored before start");
    rx_store_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL5]
        (rx_st_q == RSFU_RX_DATA && rx_v && !is_tail && !is_cr)
        |=> pay_wr_o.valid && pay_wr_o.data == $past(rx_b)) else $error("payload byte lost");
    rx_done_only_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL11]
        recv_done_o |-> rx_st_q == RSFU_RX_IDLE) else $error("done while frame open");
endmodule
`default_nettype wire

// ---- dv/rsfu_line_dev.sv ----
/* Model of the external serial device: sinks sent bytes, stalling one cycle in four,
   and plays received frames onto the line. Assumes the unit's clock and byte handshake. */
`timescale 1ns/10ps
`default_nettype none
module rsfu_line_dev
    import rsfu_pkg::*;
(
    // Clock
    input  wire logic       clk_sys_i,
    // Line side
    input  wire rsfu_byte_t line_tx_i,
    output logic            line_tx_ready_o,
    output rsfu_byte_t      line_rx_o = '{valid: 1'b0, data: 8'h5a}
);
    logic [7:0] tx_q[$];
    logic [1:0] stall_q = 2'h0;

    assign line_tx_ready_o = (stall_q != 2'h2);

    always @(posedge clk_sys_i) begin
        stall_q <= stall_q + 2'h1;
        if (line_tx_i.valid && line_tx_ready_o) begin
            tx_q.push_back(line_tx_i.data);
        end
    end

    // Frames handed in are at most 256 bytes long, codes included.
    task automatic put_frame(input logic [7:0] f[$]);
        foreach (f[i]) begin
            line_rx_o <= '{valid: 1'b1, data: f[i]};
            @(posedge clk_sys_i);
        end
        // Idle data is inverted so a stale byte never looks like a fresh one.
        line_rx_o <= '{valid: 1'b0, data: ~f[$]};
    endtask
endmodule
`default_nettype wire

// ---- dv/raw_serial_frame_unit_test.sv ----
/* Self-checking bench for the raw serial frame unit.
   Assumes the line device model beside it and a shortened 10 ms step. */
`timescale 1ns/10ps
`default_nettype none
module raw_serial_frame_unit_test;
    import rsfu_pkg::*;
    localparam int unsigned STEP = 4;
    localparam int LIMIT = 20000;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, send_cmd = 1'b0, rx_cmd = 1'b0;
    logic pay_rd_o, send_busy_o, send_done_o, recv_done_o, line_tx_ready_i;
    logic [8:0] send_len_i = 9'h000, recv_len_o, rd_idx_q = 9'h000;
    rsfu_cfg_t  cfg_i = '0;
    rsfu_byte_t pay_rd_data_i, line_tx_o, line_rx_i, pay_wr_o;
    logic [7:0] wr_q[$], fr[$], ex[$];
    int error_cnt = 0, n_checks = 0, cyc = 0, n_done = 0;

    always #50 clk_sys_i = ~clk_sys_i;
    assign pay_rd_data_i = '{valid: 1'b1, data: rd_idx_q[7:0] + 8'h20};

    rsfu_top #(.STEP_CYC(STEP)) DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cfg_i(cfg_i),
        .send_frame_cmd_alt_i(send_cmd), .send_len_i(send_len_i), .pay_rd_o(pay_rd_o),
        .pay_rd_data_i(pay_rd_data_i), .send_busy_o(send_busy_o), .send_done_o(send_done_o),
        .line_tx_o(line_tx_o), .line_tx_ready_i(line_tx_ready_i),
        .receive_frame_cmd_alt_i(rx_cmd), .line_rx_i(line_rx_i), .pay_wr_o(pay_wr_o),
        .recv_done_o(recv_done_o), .recv_len_o(recv_len_o));
    rsfu_line_dev dev (.clk_sys_i(clk_sys_i), .line_tx_i(line_tx_o),
        .line_tx_ready_o(line_tx_ready_i), .line_rx_o(line_rx_i));

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (pay_rd_o === 1'b1) rd_idx_q <= rd_idx_q + 9'h001;
        if (pay_wr_o.valid === 1'b1) wr_q.push_back(pay_wr_o.data);
        if (recv_done_o === 1'b1) n_done <= n_done + 1;
    end

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic pulse_send(input logic [8:0] len);
        send_len_i <= len;
        send_cmd   <= 1'b1;
        @(posedge clk_sys_i);
        send_cmd   <= 1'b0;
    endtask

    task automatic wait_sent();
        for (int k = 0; k < 2000 && send_done_o !== 1'b1; k++) @(negedge clk_sys_i);
        repeat (8) @(posedge clk_sys_i);
    endtask

    // Lead and single trailer around three payload bytes, two delay steps.
    task automatic t_send_byte();
        int n;
        int t0;
        logic [7:0] b;
        cfg_i <= '{1'b1, 8'h02, RSFU_END_BYTE, 8'h03, 14'd2};
        t0 = dev.tx_q.size();
        b = rd_idx_q[7:0] + 8'h20;
        @(posedge clk_sys_i);
        pulse_send(9'h003);
        for (n = 0; n < 100 && line_tx_o.valid !== 1'b1; n++) @(negedge clk_sys_i);
        chk(9'(n >= 2 * STEP && n <= 2 * STEP + 4), 9'h001);
        wait_sent();
        chk(9'(dev.tx_q.size() - t0), 9'h005);
        chk({1'b0, dev.tx_q[t0]}, 9'h002);
        for (int i = 1; i < 4; i++) chk({1'b0, dev.tx_q[t0 + i]}, {1'b0, b + 8'(i - 1)});
        chk({1'b0, dev.tx_q[t0 + 4]}, 9'h003);
    endtask

    // No codes at all: exactly the payload goes out, after one delay step.
    task automatic t_send_plain();
        int t0;
        logic [7:0] b;
        cfg_i <= '{1'b0, 8'h00, RSFU_END_NONE, 8'h00, 14'd1};
        t0 = dev.tx_q.size();
        b = rd_idx_q[7:0] + 8'h20;
        @(posedge clk_sys_i);
        pulse_send(9'h002);
        wait_sent();
        chk(9'(dev.tx_q.size() - t0), 9'h002);
        chk({1'b0, dev.tx_q[t0]}, {1'b0, b});
        chk({1'b0, dev.tx_q[t0 + 1]}, {1'b0, b + 8'h01});
    endtask

    // Overlong CRLF send is clipped to 254 payload bytes; a command mid-send is ignored.
    task automatic t_send_crlf();
        int t0;
        cfg_i <= '{1'b0, 8'h00, RSFU_END_CRLF, 8'h00, 14'd0};
        t0 = dev.tx_q.size();
        @(posedge clk_sys_i);
        pulse_send(9'h12c);
        repeat (20) @(posedge clk_sys_i);
        chk({8'h00, send_busy_o}, 9'h001);
        pulse_send(9'h005);
        wait_sent();
        chk({8'h00, send_busy_o}, 9'h000);
        chk(9'(dev.tx_q.size() - t0), 9'h100);
        chk({1'b0, dev.tx_q[t0 + 254]}, {1'b0, CODE_CR});
        chk({1'b0, dev.tx_q[t0 + 255]}, {1'b0, CODE_LF});
    endtask

    task automatic t_recv(input rsfu_cfg_t c);
        int w0;
        int d0;
        cfg_i <= c;
        w0 = wr_q.size();
        d0 = n_done;
        @(posedge clk_sys_i);
        rx_cmd <= 1'b1;
        @(posedge clk_sys_i);
        rx_cmd <= 1'b0;
        dev.put_frame(fr);
        repeat (4) @(posedge clk_sys_i);
        chk(9'(n_done - d0), 9'h001);
        chk(recv_len_o, 9'(ex.size()));
        chk(9'(wr_q.size() - w0), 9'(ex.size()));
        foreach (ex[i]) chk({1'b0, wr_q[w0 + i]}, {1'b0, ex[i]});
    endtask

    task automatic close_out();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The scenarios race a cycle ceiling; whichever ends first leads to the report.
    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        fork
            begin
                t_send_byte();
                t_send_plain();
                t_send_crlf();
                fr = '{8'h55, 8'h02, 8'h02, 8'h41, 8'h03, 8'h03, 8'h44};
                ex = '{8'h02, 8'h41};
                t_recv('{1'b1, 8'h02, RSFU_END_BYTE, 8'h03, 14'd0});
                fr = '{8'h61, 8'h0d, 8'h0a};
                ex = '{8'h61};
                t_recv('{1'b0, 8'h00, RSFU_END_CRLF, 8'h00, 14'd0});
                fr.delete();
                for (int i = 0; i < 256; i++) fr.push_back(8'(i));
                ex = fr;
                t_recv('{1'b0, 8'h00, RSFU_END_NONE, 8'h00, 14'd0});
                ex = fr[0:254];
                fr = {8'h7e, ex};
                t_recv('{1'b1, 8'h7e, RSFU_END_NONE, 8'h00, 14'd0});
            end
            begin
                wait (cyc >= LIMIT);
                error_cnt++;
            end
        join_any
        close_out();
    end
endmodule
`default_nettype wire
